// [hw/afsi_defines.svh]
`ifndef AFSI_DEFINES_SVH
`define AFSI_DEFINES_SVH
// Operation
// - Local command frame id zero suppresses response
// - Transmit status after each send unless id zero
// - Failed delivery cause coded in transmit status
// - Receive frame type 0x80 or 0xB0 by mode
// - No remote response when remote never received
// - Host skips frames with unknown type codes
// - Length MSB first counts bytes before checksum
// - Checksum is 0xFF minus byte sum
// - Transmit request type, id, options, payload offsets
// - Destination eight bytes, address low four bytes
// - Options bit 0x01 disables ack, others zero
// - Host payload at most 1398 bytes
// - Local command frame type is 0x08
// - Device applies parameter changes after command
// - Command name two ASCII bytes offsets 5,6
// - Parameter bytes mean write, none means read
// - Bytes before start delimiter are dropped
// - Frame accepted when byte sum equals 0xFF
// - Bad frame answered with status frame
// - Multi-byte values sent most significant first
`define AFSI_DELIM          8'h7e
`define AFSI_SUM_OK         8'hff
`define AFSI_T_TX64         8'h00
`define AFSI_T_ATCMD        8'h08
`define AFSI_T_REMOTE       8'h07
`define AFSI_T_RX64         8'h80
`define AFSI_T_RXIP         8'hb0
`define AFSI_T_ATRESP       8'h88
`define AFSI_T_TXSTAT       8'h89
`define AFSI_T_REMRESP      8'h87
`define AFSI_T_MODSTAT      8'h8a
`define AFSI_OFF_TYPE       16'h0003
`define AFSI_OFF_ID         16'h0004
`define AFSI_OFF_DST        16'h0005
`define AFSI_OFF_OPT        16'h000d
`define AFSI_OFF_PAY        16'h000e
`define AFSI_OFF_CMD_HI     16'h0005
`define AFSI_OFF_CMD_LO     16'h0006
`define AFSI_OFF_PARAM      16'h0007
`define AFSI_OPT_NOACK      8'h01
`define AFSI_MAX_PAY        16'h0576
`define AFSI_TX64_HDR       16'h000b
`define AFSI_AT_HDR         16'h0004
`define AFSI_MST_BADSUM     8'h01
`define AFSI_MST_BADLEN     8'h02
`define AFSI_ST_OK          8'h00
`define AFSI_ST_BADOPT      8'h21
`define AFSI_ST_OVER        8'h74
`define AFSI_ST_CMD_OK      8'h00
`define AFSI_ST_CMD_ERR     8'h01
`define AFSI_LEN_ONE        16'h0001
`define AFSI_BYTE_ZERO      8'h00
`define AFSI_BYTE_ONE       8'h01
`define AFSI_RSP_LEN        8'h03
`define AFSI_RSP_LEN_DAT    8'h04
`define AFSI_RXF_LEN        8'h02
`endif

// [hw/afsi_device.sv]
// The valid/ready byte link and the side-band network and parameter ports are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "afsi_defines.svh"
module afsi_device (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	afsi_if.device_mp       link,
	input  wire logic       mode_rxip_in,
	input  wire logic       net_rx_valid_in,
	input  wire logic [7:0] net_rx_byte_in,
	input  wire logic       net_rx_last_in,
	input  wire logic [31:0] net_rx_addr_in,
	output logic            net_rx_ready_out,
	input  wire logic       tx_done_in,
	input  wire logic [7:0] tx_cause_in,
	output logic            tx_start_out,
	output logic [31:0]     tx_addr_out,
	output logic            tx_noack_out,
	output logic            tx_byte_valid_out,
	output logic [7:0]      tx_byte_out,
	input  wire logic       rem_resp_in,
	input  wire logic [7:0] rem_status_in,
	output logic            par_wr_out,
	output logic [15:0]     par_name_out,
	output logic [7:0]      par_data_out,
	output logic            par_apply_out,
	input  wire logic [7:0] par_rd_data_in
);
	// --------------------------------------------------------------
	// Receive parser
	// --------------------------------------------------------------
	afsi_pkg::afsi_rx_e st_ff, nxt_st;
	logic [15:0] len_ff, idx_ff;
	logic [7:0]  sum_ff, type_ff, id_ff, opt_ff, txid_ff;
	logic [31:0] addr_ff;
	logic [15:0] name_ff;
	logic        par_seen_ff;
	logic        txp_ff;
	wire  logic  rx_take = link.h2d_valid && link.h2d_ready;
	wire  logic [7:0] b = link.h2d_data;
	wire  logic [7:0] sum_nx = sum_ff + b;
	wire  logic  in_tx64 = type_ff == `AFSI_T_TX64;
	wire  logic  in_at   = type_ff == `AFSI_T_ATCMD;
	wire  logic  last_body = idx_ff == len_ff + `AFSI_OFF_TYPE - `AFSI_LEN_ONE;
	wire  logic  busy;
	logic        rsp_req_ff;
	assign link.h2d_ready = !busy;

	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			afsi_pkg::AFSI_IDLE: if (rx_take && b == `AFSI_DELIM) nxt_st = afsi_pkg::AFSI_LENH;
			afsi_pkg::AFSI_LENH: if (rx_take) nxt_st = afsi_pkg::AFSI_LENL;
			afsi_pkg::AFSI_LENL: if (rx_take) nxt_st = afsi_pkg::AFSI_BODY;
			afsi_pkg::AFSI_BODY: if (rx_take && last_body) nxt_st = afsi_pkg::AFSI_SUM;
			afsi_pkg::AFSI_SUM:  if (rx_take) nxt_st = afsi_pkg::AFSI_DONE;
			afsi_pkg::AFSI_DONE: nxt_st = afsi_pkg::AFSI_IDLE;
			default:             nxt_st = afsi_pkg::AFSI_IDLE;
		endcase
	end

	wire logic pay_byte = st_ff == afsi_pkg::AFSI_BODY && rx_take && in_tx64 &&
		idx_ff >= `AFSI_OFF_PAY;
	wire logic sum_good = sum_ff == `AFSI_SUM_OK;
	wire logic len_bad  = in_tx64 ? (len_ff < `AFSI_TX64_HDR ||
		len_ff - `AFSI_TX64_HDR > `AFSI_MAX_PAY) :
		in_at ? (len_ff < `AFSI_AT_HDR) : 1'b0;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff <= afsi_pkg::AFSI_IDLE;
			len_ff <= 16'h0000;
			idx_ff <= 16'h0000;
			sum_ff <= 8'h00;
			type_ff <= 8'h00;
			id_ff <= 8'h00;
			opt_ff <= 8'h00;
			addr_ff <= 32'h0000_0000;
			name_ff <= 16'h0000;
			par_seen_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (rx_take) begin
				unique case (st_ff)
					afsi_pkg::AFSI_LENH: len_ff[15:8] <= b;
					afsi_pkg::AFSI_LENL: begin
						len_ff[7:0] <= b;
						idx_ff <= `AFSI_OFF_TYPE;
						sum_ff <= 8'h00;
						par_seen_ff <= 1'b0;
					end
					afsi_pkg::AFSI_BODY: begin
						sum_ff <= sum_nx;
						idx_ff <= idx_ff + `AFSI_LEN_ONE;
						if (idx_ff == `AFSI_OFF_TYPE) type_ff <= b;
						if (idx_ff == `AFSI_OFF_ID) id_ff <= b;
						if (in_tx64 && idx_ff >= `AFSI_OFF_DST && idx_ff < `AFSI_OFF_OPT)
							addr_ff <= {addr_ff[23:0], b};
						if (in_tx64 && idx_ff == `AFSI_OFF_OPT) opt_ff <= b;
						if (in_at && idx_ff == `AFSI_OFF_CMD_HI) name_ff[15:8] <= b;
						if (in_at && idx_ff == `AFSI_OFF_CMD_LO) name_ff[7:0] <= b;
						if (in_at && idx_ff >= `AFSI_OFF_PARAM) par_seen_ff <= 1'b1;
					end
					afsi_pkg::AFSI_SUM: sum_ff <= sum_nx;
					default: ;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// Network side and parameter outputs
	// --------------------------------------------------------------
	wire logic done = st_ff == afsi_pkg::AFSI_DONE;
	wire logic ok   = done && sum_good && !len_bad;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_start_out <= 1'b0;
			tx_addr_out <= 32'h0000_0000;
			tx_noack_out <= 1'b0;
			tx_byte_valid_out <= 1'b0;
			tx_byte_out <= 8'h00;
			par_wr_out <= 1'b0;
			par_name_out <= 16'h0000;
			par_data_out <= 8'h00;
			par_apply_out <= 1'b0;
			txid_ff <= 8'h00;
			txp_ff <= 1'b0;
		end else begin
			tx_byte_valid_out <= pay_byte;
			tx_byte_out <= b;
			tx_start_out <= ok && in_tx64 && opt_ff[7:1] == 7'h00;
			tx_addr_out <= addr_ff;
			tx_noack_out <= opt_ff[0];
			if (ok && in_tx64) begin
				txid_ff <= id_ff;
				txp_ff <= opt_ff[7:1] == 7'h00;
			end else if (tx_done_in) txp_ff <= 1'b0;
			if (st_ff == afsi_pkg::AFSI_BODY && rx_take && in_at &&
				idx_ff == `AFSI_OFF_PARAM) par_data_out <= b;
			par_name_out <= name_ff;
			par_wr_out <= ok && in_at && par_seen_ff;
			par_apply_out <= ok && in_at;
		end
	end

	// --------------------------------------------------------------
	// Response builder: type, id, status, data, checksum
	// --------------------------------------------------------------
	logic [7:0] r_type_ff, r_id_ff, r_st_ff, r_dat_ff, r_sum_ff;
	logic [2:0]  r_ph_ff;
	logic        r_dat_en_ff;
	logic [7:0]  o_data_ff;
	logic        o_valid_ff;
	logic [1:0]  rx_ph_ff;
	assign busy = rsp_req_ff || done;
	assign link.d2h_data = o_data_ff;
	assign link.d2h_valid = o_valid_ff;
	wire logic o_adv = !o_valid_ff || link.d2h_ready;
	wire logic at_rsp = ok && in_at && id_ff != `AFSI_BYTE_ZERO;
	wire logic bad_rsp = done && !(sum_good && !len_bad);
	wire logic tx_rsp = tx_done_in && txp_ff && txid_ff != `AFSI_BYTE_ZERO;
	wire logic rem_rsp = rem_resp_in;
	wire logic bad_opt = ok && in_tx64 && opt_ff[7:1] != 7'h00 &&
		id_ff != `AFSI_BYTE_ZERO;
	wire logic [7:0] rx_type = mode_rxip_in ? `AFSI_T_RXIP : `AFSI_T_RX64;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rsp_req_ff <= 1'b0;
			r_type_ff <= 8'h00;
			r_id_ff <= 8'h00;
			r_st_ff <= 8'h00;
			r_dat_ff <= 8'h00;
			r_sum_ff <= 8'h00;
			r_ph_ff <= 3'h0;
			r_dat_en_ff <= 1'b0;
			o_data_ff <= 8'h00;
			o_valid_ff <= 1'b0;
			net_rx_ready_out <= 1'b0;
			rx_ph_ff <= 2'h0;
		end else begin
			net_rx_ready_out <= 1'b0;
			if (!rsp_req_ff && (at_rsp || bad_rsp || tx_rsp || rem_rsp || bad_opt)) begin
				// Drop a previous checksum or received-data frame header byte once taken
				if (o_valid_ff && link.d2h_ready)
					o_valid_ff <= 1'b0;
				rsp_req_ff <= 1'b1;
				r_ph_ff <= 3'h0;
				r_dat_en_ff <= at_rsp && !par_seen_ff;
				r_dat_ff <= par_rd_data_in;
				r_type_ff <= at_rsp ? `AFSI_T_ATRESP : bad_rsp ? `AFSI_T_MODSTAT :
					rem_rsp ? `AFSI_T_REMRESP : `AFSI_T_TXSTAT;
				r_id_ff <= tx_rsp ? txid_ff : id_ff;
				r_st_ff <= bad_rsp ? (sum_good ? `AFSI_MST_BADLEN : `AFSI_MST_BADSUM) :
					tx_rsp ? tx_cause_in : rem_rsp ? rem_status_in :
					bad_opt ? `AFSI_ST_BADOPT : `AFSI_ST_CMD_OK;
			end else if (rsp_req_ff && o_adv) begin
				o_valid_ff <= 1'b1;
				r_ph_ff <= r_ph_ff + 3'h1;
				unique case (r_ph_ff)
					3'h0: o_data_ff <= `AFSI_DELIM;
					3'h1: o_data_ff <= `AFSI_BYTE_ZERO;
					3'h2: o_data_ff <= r_dat_en_ff ? `AFSI_RSP_LEN_DAT : `AFSI_RSP_LEN;
					3'h3: begin o_data_ff <= r_type_ff; r_sum_ff <= r_type_ff; end
					3'h4: begin o_data_ff <= r_id_ff; r_sum_ff <= r_sum_ff + r_id_ff; end
					3'h5: begin o_data_ff <= r_st_ff; r_sum_ff <= r_sum_ff + r_st_ff; end
					3'h6: if (r_dat_en_ff) begin
						o_data_ff <= r_dat_ff;
						r_sum_ff <= r_sum_ff + r_dat_ff;
						r_dat_en_ff <= 1'b0;
						r_ph_ff <= 3'h6;
					end else begin
						o_data_ff <= `AFSI_SUM_OK - r_sum_ff;
						rsp_req_ff <= 1'b0;
					end
					3'h7: begin
						// Data byte of a received-data frame
						o_data_ff <= r_dat_ff;
						r_dat_en_ff <= 1'b0;
						r_ph_ff <= 3'h6;
					end
				endcase
			end else if (!rsp_req_ff && o_adv && net_rx_valid_in && !net_rx_ready_out) begin
				// Short received-data frame: type, byte, checksum
				o_valid_ff <= 1'b1;
				rx_ph_ff <= rx_ph_ff + 2'h1;
				unique case (rx_ph_ff)
					2'h0: o_data_ff <= `AFSI_DELIM;
					2'h1: o_data_ff <= `AFSI_BYTE_ZERO;
					2'h2: o_data_ff <= `AFSI_RXF_LEN;
					2'h3: begin
						o_data_ff <= rx_type;
						r_sum_ff <= rx_type + net_rx_byte_in;
						r_dat_ff <= net_rx_byte_in;
						rsp_req_ff <= 1'b1;
						r_ph_ff <= 3'h7;
						net_rx_ready_out <= 1'b1;
					end
				endcase
			end else if (o_valid_ff && link.d2h_ready) begin
				o_valid_ff <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [hw/afsi_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "afsi_defines.svh"
module afsi_host (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	afsi_if.host_mp          link,
	input  wire logic        cmd_valid_in,
	input  wire logic [7:0]  cmd_byte_in,
	input  wire logic        cmd_last_in,
	output logic             cmd_ready_out,
	output logic             rsp_valid_out,
	output logic [7:0]       rsp_type_out,
	output logic [7:0]       rsp_id_out,
	output logic [7:0]       rsp_status_out,
	output logic             rsp_bad_out
);
	// --------------------------------------------------------------
	// Frame sender: wraps frame data with delimiter, length, checksum
	// --------------------------------------------------------------
	logic [7:0]  buf_ff [0:1411];
	logic [10:0] n_ff, k_ff;
	logic [7:0]  s_ff, hd_ff;
	logic        hv_ff;
	logic [2:0]  ph_ff;
	assign link.h2d_data = hd_ff;
	assign link.h2d_valid = hv_ff;
	wire logic adv = !hv_ff || link.h2d_ready;
	wire logic [15:0] n16 = {5'h00, n_ff};
	always_ff @(posedge clk_in) if (cmd_valid_in && cmd_ready_out && ph_ff == 3'h0)
		buf_ff[n_ff] <= cmd_byte_in;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			n_ff <= 11'h000; k_ff <= 11'h000; s_ff <= 8'h00;
			hd_ff <= 8'h00; hv_ff <= 1'b0; ph_ff <= 3'h0;
			cmd_ready_out <= 1'b1;
		end else begin
			if (ph_ff == 3'h0) begin
				if (cmd_valid_in && cmd_ready_out) begin
					n_ff <= n_ff + 11'h001;
					s_ff <= s_ff + cmd_byte_in;
					if (cmd_last_in) begin ph_ff <= 3'h1; cmd_ready_out <= 1'b0; end
				end
				if (hv_ff && link.h2d_ready) hv_ff <= 1'b0;
			end else if (adv) begin
				hv_ff <= 1'b1;
				unique case (ph_ff)
					3'h1: begin hd_ff <= `AFSI_DELIM; ph_ff <= 3'h2; end
					3'h2: begin hd_ff <= n16[15:8]; ph_ff <= 3'h3; end
					3'h3: begin hd_ff <= n16[7:0]; ph_ff <= 3'h4; k_ff <= 11'h000; end
					3'h4: begin
						hd_ff <= buf_ff[k_ff];
						k_ff <= k_ff + 11'h001;
						if (k_ff + 11'h001 == n_ff) ph_ff <= 3'h5;
					end
					3'h5: begin hd_ff <= `AFSI_SUM_OK - s_ff; ph_ff <= 3'h6; end
					default: begin
						hv_ff <= 1'b0; ph_ff <= 3'h0; n_ff <= 11'h000;
						s_ff <= 8'h00; cmd_ready_out <= 1'b1;
					end
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// Response receiver: skips unknown types
	// --------------------------------------------------------------
	logic [2:0]  rp_ff;
	logic [15:0] rl_ff, ri_ff;
	logic [7:0]  rs_ff, rt_ff, rid_ff, rst_ff;
	wire  logic  take = link.d2h_valid && link.d2h_ready;
	wire  logic [7:0] d = link.d2h_data;
	wire  logic known = rt_ff == `AFSI_T_ATRESP || rt_ff == `AFSI_T_TXSTAT ||
		rt_ff == `AFSI_T_REMRESP || rt_ff == `AFSI_T_MODSTAT ||
		rt_ff == `AFSI_T_RX64 || rt_ff == `AFSI_T_RXIP;
	assign link.d2h_ready = 1'b1;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rp_ff <= 3'h0; rl_ff <= 16'h0000; ri_ff <= 16'h0000; rs_ff <= 8'h00;
			rt_ff <= 8'h00; rid_ff <= 8'h00; rst_ff <= 8'h00;
			rsp_valid_out <= 1'b0; rsp_type_out <= 8'h00; rsp_id_out <= 8'h00;
			rsp_status_out <= 8'h00; rsp_bad_out <= 1'b0;
		end else begin
			rsp_valid_out <= 1'b0;
			if (take) begin
				unique case (rp_ff)
					3'h0: if (d == `AFSI_DELIM) rp_ff <= 3'h1;
					3'h1: begin rl_ff[15:8] <= d; rp_ff <= 3'h2; end
					3'h2: begin rl_ff[7:0] <= d; rp_ff <= 3'h3; ri_ff <= 16'h0000; rs_ff <= 8'h00; end
					3'h3: begin
						rs_ff <= rs_ff + d;
						ri_ff <= ri_ff + 16'h0001;
						if (ri_ff == 16'h0000) rt_ff <= d;
						if (ri_ff == 16'h0001) rid_ff <= d;
						if (ri_ff == 16'h0002) rst_ff <= d;
						if (ri_ff + 16'h0001 == rl_ff) rp_ff <= 3'h4;
					end
					default: begin
						rp_ff <= 3'h0;
						rsp_valid_out <= known;
						rsp_bad_out <= rs_ff + d != `AFSI_SUM_OK;
						rsp_type_out <= rt_ff;
						rsp_id_out <= rid_ff;
						rsp_status_out <= rst_ff;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [hw/afsi_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface afsi_if;
	logic [7:0] h2d_data;
	logic       h2d_valid;
	logic       h2d_ready;
	logic [7:0] d2h_data;
	logic       d2h_valid;
	logic       d2h_ready;
	modport device_mp (
		input  h2d_data, h2d_valid, d2h_ready,
		output h2d_ready, d2h_data, d2h_valid
	);
	modport host_mp (
		output h2d_data, h2d_valid, d2h_ready,
		input  h2d_ready, d2h_data, d2h_valid
	);
endinterface
`default_nettype wire

// [hw/afsi_pkg.sv]
`default_nettype none
package afsi_pkg;
	typedef logic [7:0]  afsi_byte_t;
	typedef logic [15:0] afsi_len_t;
	typedef enum logic [2:0] {
		AFSI_IDLE = 3'b000,
		AFSI_LENH = 3'b001,
		AFSI_LENL = 3'b011,
		AFSI_BODY = 3'b010,
		AFSI_SUM  = 3'b110,
		AFSI_DONE = 3'b100
	} afsi_rx_e;
endpackage
`default_nettype wire

// [sim/afsi_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "afsi_defines.svh"
module afsi_monitor (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_valid,
	input wire logic       h2d_ready,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_valid,
	input wire logic       d2h_ready
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// -------------------
	// Frame byte trackers
	// -------------------
	logic [15:0] hi_ff, hl_ff, di_ff, dl_ff;
	logic [7:0]  hs_ff, ds_ff;
	wire         h_go = h2d_valid & h2d_ready;
	wire         d_go = d2h_valid & d2h_ready;
	wire         h_end = hi_ff > 16'h0002 && hi_ff == hl_ff + 16'h0003;
	wire         d_end = di_ff > 16'h0002 && di_ff == dl_ff + 16'h0003;
	wire  [15:0] nxt_hi = h_end ? 16'h0000 : hi_ff + 16'h0001;
	wire  [15:0] nxt_di = d_end ? 16'h0000 : di_ff + 16'h0001;
	wire  [15:0] nxt_hl = hi_ff == 16'h0001 ? {h2d_data, 8'h00} :
		hi_ff == 16'h0002 ? {hl_ff[15:8], h2d_data} : hl_ff;
	wire  [15:0] nxt_dl = di_ff == 16'h0001 ? {d2h_data, 8'h00} :
		di_ff == 16'h0002 ? {dl_ff[15:8], d2h_data} : dl_ff;
	wire  [7:0]  nxt_hs = hi_ff < 16'h0003 ? 8'h00 : hs_ff + h2d_data;
	wire  [7:0]  nxt_ds = di_ff < 16'h0003 ? 8'h00 : ds_ff + d2h_data;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			{hi_ff, hl_ff, hs_ff} <= '0;
		else if (h_go)
			{hi_ff, hl_ff, hs_ff} <= {nxt_hi, nxt_hl, nxt_hs};
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			{di_ff, dl_ff, ds_ff} <= '0;
		else if (d_go)
			{di_ff, dl_ff, ds_ff} <= {nxt_di, nxt_dl, nxt_ds};
	end
	// ----------
	// Properties
	// ----------
	AST_H_HOLD: assert property (h2d_valid && !h2d_ready |=>
		h2d_valid && $stable(h2d_data)) else $error("host byte dropped");
	AST_D_HOLD: assert property (d2h_valid && !d2h_ready |=>
		d2h_valid && $stable(d2h_data)) else $error("device byte dropped");
	AST_H_DELIM: assert property (h_go && hi_ff == 16'h0000 |->
		h2d_data == `AFSI_DELIM) else $error("host frame start");
	AST_D_DELIM: assert property (d_go && di_ff == 16'h0000 |->
		d2h_data == `AFSI_DELIM) else $error("device frame start");
	AST_H_SUM: assert property (h_go && h_end |->
		(hs_ff + h2d_data) == `AFSI_SUM_OK) else $error("host checksum");
	AST_D_SUM: assert property (d_go && d_end |->
		(ds_ff + d2h_data) == `AFSI_SUM_OK) else $error("device checksum");
	AST_H_TYPE: assert property (h_go && hi_ff == 16'h0003 |->
		h2d_data inside {8'h00, 8'h07, 8'h08}) else $error("host type");
	AST_D_TYPE: assert property (d_go && di_ff == 16'h0003 |->
		d2h_data inside {8'h80, 8'hb0, 8'h87, 8'h88, 8'h89, 8'h8a})
		else $error("device type");
	AST_D_LEN: assert property (d_go && di_ff == 16'h0002 |->
		dl_ff[15:8] == 8'h00 && d2h_data inside {8'h02, 8'h03, 8'h04})
		else $error("device length");
endmodule
`default_nettype wire

// [sim/afsi_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_in = 1'b0, rst_n_in = 1'b0, mode_rxip_in = 1'b0;
	logic        net_rx_valid_in = 1'b0, net_rx_last_in = 1'b1;
	logic        tx_done_in = 1'b0, rem_resp_in = 1'b0;
	logic        cmd_valid_in = 1'b0, cmd_last_in = 1'b0;
	logic [7:0]  net_rx_byte_in = 8'h00, tx_cause_in = 8'h00;
	logic [7:0]  rem_status_in = 8'h00, cmd_byte_in = 8'h00;
	logic [7:0]  par_rd_data_in = 8'h3c;
	logic [31:0] net_rx_addr_in = 32'hc0a8_0064;
	logic        cmd_ready_out, rsp_valid_out, rsp_bad_out, net_rx_ready_out;
	logic        tx_start_out, tx_noack_out, tx_byte_valid_out;
	logic        par_wr_out, par_apply_out;
	logic [7:0]  rsp_type_out, rsp_id_out, rsp_status_out, tx_byte_out;
	logic [7:0]  par_data_out, snap;
	logic [15:0] par_name_out;
	logic [31:0] tx_addr_out;
	logic [23:0] wr_key;
	logic [32:0] st_key;
	logic [7:0]  f[$], tx_bytes[$];
	logic [23:0] rsp_q[$];
	int          fails = 0, num_checks = 0, n_wr = 0, n_apply = 0;
	int          n_start = 0;
	afsi_if link_a ();
	afsi_if link_b ();
	wire  [3:0]  rdy = {link_b.d2h_valid, link_b.h2d_ready, cmd_ready_out,
		net_rx_ready_out};
	afsi_host afsi_host_inst (.clk_in, .rst_n_in, .link(link_a), .cmd_valid_in,
		.cmd_byte_in, .cmd_last_in, .cmd_ready_out, .rsp_valid_out,
		.rsp_type_out, .rsp_id_out, .rsp_status_out, .rsp_bad_out);
	afsi_device afsi_device_inst (.clk_in, .rst_n_in, .link(link_a),
		.mode_rxip_in, .net_rx_valid_in, .net_rx_byte_in, .net_rx_last_in,
		.net_rx_addr_in, .net_rx_ready_out, .tx_done_in, .tx_cause_in,
		.tx_start_out, .tx_addr_out, .tx_noack_out, .tx_byte_valid_out,
		.tx_byte_out, .rem_resp_in, .rem_status_in, .par_wr_out,
		.par_name_out, .par_data_out, .par_apply_out, .par_rd_data_in);
	afsi_device afsi_device_inst_b (.clk_in, .rst_n_in, .link(link_b),
		.mode_rxip_in, .net_rx_valid_in(1'b0), .net_rx_byte_in,
		.net_rx_last_in, .net_rx_addr_in, .net_rx_ready_out(), .tx_done_in,
		.tx_cause_in, .tx_start_out(), .tx_addr_out(), .tx_noack_out(),
		.tx_byte_valid_out(), .tx_byte_out(), .rem_resp_in, .rem_status_in,
		.par_wr_out(), .par_name_out(), .par_data_out(), .par_apply_out(),
		.par_rd_data_in);
	afsi_monitor afsi_monitor_inst (.clk_in, .rst_n_in,
		.h2d_data(link_a.h2d_data), .h2d_valid(link_a.h2d_valid),
		.h2d_ready(link_a.h2d_ready), .d2h_data(link_a.d2h_data),
		.d2h_valid(link_a.d2h_valid), .d2h_ready(link_a.d2h_ready));
	always #4 clk_in = ~clk_in;
	// ------------------------------
	// Event capture on settled edges
	// ------------------------------
	always @(negedge clk_in) begin
		if (rsp_valid_out === 1'b1) begin
			rsp_q.push_back({rsp_type_out, rsp_id_out, rsp_status_out});
			chk(rsp_bad_out, 1'b0);
		end
		if (par_wr_out === 1'b1) begin
			n_wr++;
			wr_key = {par_name_out, par_data_out};
		end
		if (par_apply_out === 1'b1)
			n_apply++;
		if (tx_start_out === 1'b1) begin
			n_start++;
			st_key = {tx_addr_out, tx_noack_out};
		end
		if (tx_byte_valid_out === 1'b1)
			tx_bytes.push_back(tx_byte_out);
	end
	// -----
	// Tasks
	// -----
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(input int k);
		int n;
		logic r;
		n = 0;
		do begin
			@(negedge clk_in);
			r = rdy[k];
			snap = link_b.d2h_data;
			@(posedge clk_in);
			n++;
		end while (r !== 1'b1 && n < 1000);
	endtask
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			cmd_valid_in <= 1'b1;
			cmd_byte_in <= b[i];
			cmd_last_in <= (i == b.size() - 1);
			wait_hi(1);
		end
		cmd_valid_in <= 1'b0;
		cmd_last_in <= 1'b0;
	endtask
	task automatic b_send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			link_b.h2d_valid <= 1'b1;
			link_b.h2d_data <= b[i];
			wait_hi(2);
		end
		link_b.h2d_valid <= 1'b0;
		link_b.h2d_data <= ~b[b.size() - 1];
	endtask
	task automatic b_frame();
		logic [7:0] s;
		f = {};
		s = 8'h00;
		link_b.d2h_ready <= 1'b1;
		repeat (3) begin
			wait_hi(3);
			f.push_back(snap);
		end
		repeat ({f[1], f[2]} + 16'h0001) begin
			wait_hi(3);
			f.push_back(snap);
			s += snap;
		end
		link_b.d2h_ready <= 1'b0;
		chk(s, 8'hff);
	endtask
	task automatic exp_rsp(input logic [23:0] e, input logic [23:0] m = '1);
		int n;
		n = 0;
		while (rsp_q.size() == 0 && n < 400) begin
			@(posedge clk_in);
			n++;
		end
		if (rsp_q.size() == 0)
			rsp_q.push_back('x);
		chk(rsp_q.pop_front() & m, e);
	endtask
	task automatic no_rsp();
		repeat (80) @(posedge clk_in);
		chk(rsp_q.size(), 8'h00);
	endtask
	task automatic tx64(input logic [7:0] id, input logic [7:0] opt);
		send('{8'h00, id, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h00,
			8'h64, opt, 8'haa, 8'hbb});
	endtask
	task automatic done(input logic [7:0] c, input int k);
		int n;
		n = 0;
		while (n_start < k && n < 400) begin
			@(posedge clk_in);
			n++;
		end
		tx_done_in <= 1'b1;
		tx_cause_in <= c;
		@(posedge clk_in);
		tx_done_in <= 1'b0;
	endtask
	task automatic stop_test();
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk_in);
		fails++;
		stop_test();
	end
	initial begin
		link_b.h2d_valid = 1'b0;
		link_b.h2d_data = 8'h00;
		link_b.d2h_ready = 1'b0;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		b_send('{8'h11, 8'h22, 8'h7e, 8'h00, 8'h04, 8'h08, 8'h01, 8'h4e,
			8'h49, 8'h60});
		b_frame();
		chk({f[2], f[3], f[5]}, 24'h03_8a01);
		b_send('{8'h55, 8'h7e, 8'h00, 8'h04, 8'h08, 8'h03, 8'h4e, 8'h49,
			8'h5d});
		b_frame();
		chk({f[0], f[1], f[2], f[3], f[4], f[5], f[6]}, 56'h7e_0004_8803_003c);
		send('{8'h08, 8'h01, 8'h4e, 8'h49, 8'h55});
		exp_rsp(24'h88_0100);
		chk({n_wr[7:0], wr_key}, 32'h014e_4955);
		chk(n_apply, 8'h01);
		send('{8'h08, 8'h02, 8'h4e, 8'h49});
		exp_rsp(24'h88_0200);
		chk({n_wr[7:0], n_apply[7:0]}, 16'h0102);
		send('{8'h08, 8'h00, 8'h4e, 8'h49, 8'h77});
		no_rsp();
		chk({n_wr[7:0], n_apply[7:0]}, 16'h0203);
		tx64(8'h05, 8'h01);
		done(8'h00, 1);
		exp_rsp(24'h89_0500);
		chk(st_key, {32'hc0a8_0064, 1'b1});
		chk({tx_bytes[0], tx_bytes[1]}, 16'haabb);
		tx64(8'h06, 8'h00);
		@(posedge clk_in);
		// Status reply lands while the host streams the next frame
		tx64(8'h00, 8'h00);
		done(8'h74, 2);
		exp_rsp(24'h89_0674);
		chk(st_key[0], 1'b0);
		done(8'h00, 3);
		no_rsp();
		tx64(8'h07, 8'h02);
		exp_rsp(24'h89_0721);
		chk(n_start, 8'h03);
		for (int m = 0; m < 2; m++) begin
			mode_rxip_in <= m[0];
			net_rx_valid_in <= 1'b1;
			net_rx_byte_in <= 8'h5a;
			wait_hi(0);
			net_rx_valid_in <= 1'b0;
			exp_rsp({m[0] ? 8'hb0 : 8'h80, 16'h0000}, 24'hff_0000);
		end
		send('{8'h07, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h00,
			8'h64, 8'h02, 8'h44, 8'h4c});
		no_rsp();
		rem_resp_in <= 1'b1;
		rem_status_in <= 8'h03;
		@(posedge clk_in);
		rem_resp_in <= 1'b0;
		exp_rsp(24'h87_0903);
		stop_test();
	end
endmodule
`default_nettype wire
